// file: cbd_exec.sv
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "cbd_map.svh"
module cbd_exec
  import cbd_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // instruction issue
  input  wire logic        ins_valid,
  input  wire logic        ins_prefix,
  input  wire logic [7:0]  ins_opcode,
  input  wire logic [7:0]  ins_byte1,
  input  wire logic [7:0]  ins_byte2,
  input  wire logic [7:0]  ins_byte3,
  input  wire logic [15:0] ins_pc_next,
  input  wire logic [7:0]  register_pointer,
  output logic             ins_done,
  output logic             busy,
  output logic             pc_load,
  output logic [15:0]      pc_target,
  // register file
  output logic [11:0]      rf_addr,
  output logic             rf_rd,
  output logic             rf_we,
  output logic [7:0]       rf_wdata,
  input  wire logic [7:0]  rf_rdata,
  // control port
  input  wire logic [1:0]  ctl_addr,
  input  wire logic [7:0]  ctl_wdata,
  input  wire logic        ctl_wr,
  input  wire logic        ctl_rd,
  output logic [7:0]       ctl_rdata,
  // processor state
  output logic [7:0]       flags,
  output logic [7:0]       interrupt_control_register
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic        rst_q1;
  logic        rst_sync_b;
  cbd_state_t  state;
  cbd_kind_t   kind;
  cbd_kind_t   dec_kind;
  logic        dec_indir;
  logic        dec_srcreg;
  logic        dec_borrow;
  logic [11:0] dec_dst;
  logic [11:0] dec_src;
  logic        borrow;
  logic        srcreg;
  logic [11:0] dst_addr;
  logic [11:0] src_addr;
  logic [7:0]  rp;
  logic [7:0]  dhi;
  logic [7:0]  dlo;
  logic [7:0]  sval;
  logic [15:0] pc_base;
  logic [7:0]  offset;
  logic [11:0] ptr_eff;
  logic [8:0]  diff9;
  logic [7:0]  dec_res;
  logic [15:0] word_res;
  logic [7:0]  bcd_res;
  logic        bcd_c;
  logic [7:0]  wr_byte;
  logic [7:0]  next_flags;
  logic        taken;
  logic        bad_op;
  logic        take;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q1     <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_q1     <= 1'b1;
      rst_sync_b <= rst_q1;
    end
  end

  // ---------------------------------------------------------------
  // address escapes
  // ---------------------------------------------------------------
  // long address, EE high byte selects a working register
  function automatic logic [11:0] esc12(input logic [11:0] a,
                                        input logic [7:0]  p);
    if (a[11:4] == `CBD_ESC_BYTE) esc12 = {p[3:0], p[7:4], a[3:0]};
    else esc12 = a;
  endfunction : esc12

  // short address, E high nibble selects a working register
  function automatic logic [11:0] esc8(input logic [7:0] a,
                                       input logic [7:0] p);
    if (a[7:4] == `CBD_ESC_NIB) esc8 = {p[3:0], p[7:4], a[3:0]};
    else esc8 = {p[3:0], a};
  endfunction : esc8

  // ---------------------------------------------------------------
  // instruction decode
  // ---------------------------------------------------------------
  assign take = (state == st_idle) && ins_valid;

  always_comb begin
    dec_kind   = k_bad;
    dec_indir  = 1'b0;
    dec_srcreg = 1'b0;
    dec_borrow = ins_prefix;
    dec_dst    = esc8(ins_byte1, register_pointer);
    dec_src    = esc12({ins_byte1, ins_byte2[7:4]}, register_pointer);
    if (ins_opcode == `CBD_OP_CMPX_R) begin
      dec_kind   = k_cmp;
      dec_srcreg = 1'b1;
      dec_dst    = esc12({ins_byte2[3:0], ins_byte3}, register_pointer);
    end else if (ins_opcode == `CBD_OP_CMPX_I) begin
      dec_kind   = k_cmp;
      dec_dst    = esc12({ins_byte2[3:0], ins_byte3}, register_pointer);
    end else if (ins_prefix) begin
      dec_kind   = k_bad;
    end else if (ins_opcode == `CBD_OP_BCD_R ||
                 ins_opcode == `CBD_OP_BCD_I) begin
      dec_kind   = k_bcd;
      dec_indir  = ins_opcode[0];
    end else if (ins_opcode == `CBD_OP_DEC_R ||
                 ins_opcode == `CBD_OP_DEC_I) begin
      dec_kind   = k_dec;
      dec_indir  = ins_opcode[0];
    end else if (ins_opcode == `CBD_OP_COUNT_DOWN_PAIR_R ||
                 ins_opcode == `CBD_OP_COUNT_DOWN_PAIR_I) begin
      dec_kind   = k_count_down_pair;
      dec_indir  = ins_opcode[0];
      if (!ins_opcode[0]) dec_dst[0] = 1'b0;
    end else if (ins_opcode == `CBD_OP_MASK_ALL) begin
      dec_kind   = k_mask;
    end else if (ins_opcode[3:0] == `CBD_OP_LOOP_LO) begin
      dec_kind   = k_loop;
      dec_dst    = {register_pointer[3:0], register_pointer[7:4],
                    ins_opcode[7:4]};
    end
  end

  // pointer contents give the effective address, pairs forced even
  always_comb begin
    ptr_eff = {rp[3:0], rf_rdata};
    if (kind == k_count_down_pair) ptr_eff[0] = 1'b0;
  end

  // ---------------------------------------------------------------
  // arithmetic
  // ---------------------------------------------------------------
  assign diff9    = {1'b0, dhi} - {1'b0, sval}
                  - {8'h00, borrow & flags[`CBD_F_C]};
  assign dec_res  = dhi - 8'h01;
  assign word_res = {dhi, dlo} - 16'h0001;

  cbd_bcd_adj u_bcd (
    .value  (dhi),
    .c_in   (flags[`CBD_F_C]),
    .h_in   (flags[`CBD_F_H]),
    .sub    (flags[`CBD_F_D]),
    .result (bcd_res),
    .c_out  (bcd_c)
  );

  // flag results per kind
  always_comb begin
    next_flags = flags;
    wr_byte    = dec_res;
    unique case (kind)
      k_cmp: begin
        next_flags[`CBD_F_C] = diff9[8];
        next_flags[`CBD_F_Z] = (diff9[7:0] == 8'h00) &&
                               (!borrow || flags[`CBD_F_Z]);
        next_flags[`CBD_F_S] = diff9[7];
        next_flags[`CBD_F_V] = (dhi[7] ^ sval[7]) &
                               (diff9[7] ^ dhi[7]);
      end
      k_bcd: begin
        wr_byte              = bcd_res;
        next_flags[`CBD_F_C] = bcd_c;
        next_flags[`CBD_F_Z] = bcd_res == 8'h00;
        next_flags[`CBD_F_S] = bcd_res[7];               // V held
      end
      k_dec: begin
        next_flags[`CBD_F_Z] = dec_res == 8'h00;
        next_flags[`CBD_F_S] = dec_res[7];
        next_flags[`CBD_F_V] = dhi == 8'h80;
      end
      k_count_down_pair: begin
        wr_byte              = word_res[15:8];
        next_flags[`CBD_F_Z] = word_res == 16'h0000;
        next_flags[`CBD_F_S] = word_res[15];
        next_flags[`CBD_F_V] = {dhi, dlo} == 16'h8000;
      end
      default: next_flags = flags;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state     <= st_idle;
      kind      <= k_bad;
      borrow    <= 1'b0;
      srcreg    <= 1'b0;
      dst_addr  <= 12'h000;
      src_addr  <= 12'h000;
      rp        <= 8'h00;
      dhi       <= 8'h00;
      dlo       <= 8'h00;
      sval      <= 8'h00;
      pc_base   <= 16'h0000;
      offset    <= 8'h00;
      busy      <= 1'b0;
      ins_done  <= 1'b0;
      pc_load   <= 1'b0;
      pc_target <= 16'h0000;
      rf_addr   <= 12'h000;
      rf_rd     <= 1'b0;
      rf_we     <= 1'b0;
      rf_wdata  <= 8'h00;
    end else begin
      rf_rd    <= 1'b0;
      rf_we    <= 1'b0;
      ins_done <= 1'b0;
      pc_load  <= 1'b0;
      unique case (state)
        st_idle: if (ins_valid) begin
          kind     <= dec_kind;
          borrow   <= dec_borrow;
          srcreg   <= dec_srcreg;
          dst_addr <= dec_dst;
          src_addr <= dec_src;
          rp       <= register_pointer;
          sval     <= ins_byte1;
          offset   <= ins_byte1;
          pc_base  <= ins_pc_next;
          if (dec_kind == k_mask || dec_kind == k_bad) begin
            ins_done <= 1'b1;
          end else begin
            busy    <= 1'b1;
            rf_rd   <= 1'b1;
            rf_addr <= dec_dst;
            state   <= dec_indir ? st_ptr : st_dhi;
          end
        end
        st_ptr: begin
          dst_addr <= ptr_eff;
          rf_rd    <= 1'b1;
          rf_addr  <= ptr_eff;
          state    <= st_dhi;
        end
        st_dhi: begin
          dhi <= rf_rdata;
          if (kind == k_count_down_pair) begin
            rf_rd   <= 1'b1;
            rf_addr <= dst_addr | 12'h001;
            state   <= st_dlo;
          end else if (srcreg) begin
            rf_rd   <= 1'b1;
            rf_addr <= src_addr;
            state   <= st_src;
          end else begin
            state <= st_exec;
          end
        end
        st_dlo: begin
          dlo   <= rf_rdata;
          state <= st_exec;
        end
        st_src: begin
          sval  <= rf_rdata;
          state <= st_exec;
        end
        st_exec: begin
          rf_addr  <= dst_addr;
          rf_wdata <= wr_byte;
          rf_we    <= kind != k_cmp;
          if (kind == k_count_down_pair) begin
            state <= st_wlo;
          end else begin
            ins_done <= 1'b1;
            busy     <= 1'b0;
            state    <= st_idle;
          end
          if (kind == k_loop && dec_res != 8'h00) begin
            pc_load   <= 1'b1;
            pc_target <= pc_base + {{8{offset[7]}}, offset};
          end
        end
        st_wlo: begin
          rf_we    <= 1'b1;
          rf_addr  <= dst_addr | 12'h001;
          rf_wdata <= word_res[7:0];
          ins_done <= 1'b1;
          busy     <= 1'b0;
          state    <= st_idle;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // flags, interrupt control and status
  // ---------------------------------------------------------------
  // execution wins over a software write in the same cycle
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) flags <= `CBD_FLAGS_RST;
    else if (state == st_exec) flags <= next_flags;
    else if (ctl_wr && ctl_addr == `CBD_OFS_FLAGS) flags <= ctl_wdata;
  end

  // global enable drops on the mask-all opcode
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      interrupt_control_register <= `CBD_ICTL_RST;
    end else begin
      if (ctl_wr && ctl_addr == `CBD_OFS_ICTL)
        interrupt_control_register <= ctl_wdata;
      if (take && dec_kind == k_mask)
        interrupt_control_register[`CBD_IE_BIT] <= 1'b0;
    end
  end

  // bad_op sticky, set beats write-one-to-clear; taken follows the last loop
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      taken  <= 1'b0;
      bad_op <= 1'b0;
    end else begin
      if (state == st_exec && kind == k_loop) taken <= dec_res != 8'h00;
      if (take && dec_kind == k_bad) bad_op <= 1'b1;
      else if (ctl_wr && ctl_addr == `CBD_OFS_STAT &&
               ctl_wdata[`CBD_ST_BADOP]) bad_op <= 1'b0;
    end
  end

  // read data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ctl_rdata <= 8'h00;
    end else if (ctl_rd) begin
      unique case (ctl_addr)
        `CBD_OFS_FLAGS: ctl_rdata <= flags;
        `CBD_OFS_ICTL:  ctl_rdata <= interrupt_control_register;
        `CBD_OFS_STAT:  ctl_rdata <= {5'h00, bad_op, taken, busy};
        default:        ctl_rdata <= 8'h00;
      endcase
    end else begin
      ctl_rdata <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_b);

  sequence seq_take_mem;
    take && dec_kind != k_mask && dec_kind != k_bad;
  endsequence
  sequence seq_pair_write;
    rf_we && !rf_addr[0] ##1 rf_we && rf_addr[0] && ins_done;
  endsequence

  chk_first_read: assert property (seq_take_mem |=> rf_rd && busy)
    else $error("no register read after accept");
  chk_mask_ie: assert property (
    take && dec_kind == k_mask && !ctl_wr
    |=> !interrupt_control_register[`CBD_IE_BIT] && ins_done
        && $stable(flags))
    else $error("mask-all did not clear enable");
  chk_cmp_no_write: assert property (
    busy && kind == k_cmp |-> !rf_we)
    else $error("compare wrote an operand");
  chk_chain_zero: assert property (
    state == st_exec && kind == k_cmp && borrow && !flags[`CBD_F_Z]
    |=> !flags[`CBD_F_Z])
    else $error("borrow compare set zero from zero");
  chk_dec_carry: assert property (
    state == st_exec && kind == k_dec
    |=> flags[`CBD_F_C] == $past(flags[`CBD_F_C]))
    else $error("byte decrement moved carry");
  chk_pair_even: assert property (
    state == st_wlo |-> seq_pair_write)
    else $error("pair write not even then odd");
  chk_loop_target: assert property (
    pc_load |-> pc_target == pc_base + {{8{offset[7]}}, offset})
    else $error("loop target wrong");
  chk_loop_flags: assert property (
    state == st_exec && kind == k_loop |=> $stable(flags))
    else $error("loop changed flags");
  chk_loop_exit: assert property (
    state == st_exec && kind == k_loop && dhi == 8'h01
    |=> !pc_load && ins_done && rf_we && rf_wdata == 8'h00)
    else $error("loop branched on zero");
  chk_bcd_keep_v: assert property (
    state == st_exec && kind == k_bcd
    |=> flags[`CBD_F_V] == $past(flags[`CBD_F_V]))
    else $error("bcd correction moved overflow");
endmodule : cbd_exec
`default_nettype wire

// file: cbd_map.svh
`ifndef CBD_MAP_SVH
`define CBD_MAP_SVH
// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define CBD_OP_PREFIX   8'h1F
`define CBD_OP_CMPX_R   8'hA8
`define CBD_OP_CMPX_I   8'hA9
`define CBD_OP_BCD_R    8'h40
`define CBD_OP_BCD_I    8'h41
`define CBD_OP_DEC_R    8'h30
`define CBD_OP_DEC_I    8'h31
`define CBD_OP_COUNT_DOWN_PAIR_R   8'h80
`define CBD_OP_COUNT_DOWN_PAIR_I   8'h81
`define CBD_OP_MASK_ALL 8'h8F
`define CBD_OP_LOOP_LO  4'hA
// ---------------------------------------------------------------
// working register escapes
// ---------------------------------------------------------------
`define CBD_ESC_BYTE    8'hEE
`define CBD_ESC_NIB     4'hE
// ---------------------------------------------------------------
// flag bit positions
// ---------------------------------------------------------------
`define CBD_F_C         7
`define CBD_F_Z         6
`define CBD_F_S         5
`define CBD_F_V         4
`define CBD_F_D         3
`define CBD_F_H         2
`define CBD_IE_BIT      7
// ---------------------------------------------------------------
// bcd corrections
// ---------------------------------------------------------------
`define CBD_ADJ_NONE    8'h00
`define CBD_ADJ_LO      8'h06
`define CBD_ADJ_HI      8'h60
`define CBD_ADJ_BOTH    8'h66
`define CBD_ADJ_SUB_H   8'hFA
`define CBD_ADJ_SUB_C   8'hA0
`define CBD_ADJ_SUB_CH  8'h9A
`define CBD_BCD_MAX     4'h9
// ---------------------------------------------------------------
// control port map and reset values
// ---------------------------------------------------------------
`define CBD_OFS_FLAGS   2'h0
`define CBD_OFS_ICTL    2'h1
`define CBD_OFS_STAT    2'h2
`define CBD_FLAGS_RST   8'h00
`define CBD_ICTL_RST    8'h00
`define CBD_ST_BUSY     0
`define CBD_ST_TAKEN    1
`define CBD_ST_BADOP    2
`endif

// file: cbd_pkg.sv
package cbd_pkg;
  // sequencer states
  typedef enum logic [2:0] {
    st_idle, st_ptr, st_dhi, st_dlo, st_src, st_exec, st_wlo
  } cbd_state_t;
  // operation kinds
  typedef enum logic [2:0] {
    k_cmp, k_bcd, k_dec, k_count_down_pair, k_mask, k_loop, k_bad
  } cbd_kind_t;
endpackage : cbd_pkg

// file: cbd_bcd_adj.sv
`timescale 1ns/10ps
`default_nettype none
`include "cbd_map.svh"
module cbd_bcd_adj (
  // byte and flags before correction
  input  wire logic [7:0] value,
  input  wire logic       c_in,
  input  wire logic       h_in,
  input  wire logic       sub,
  // corrected byte and carry
  output logic      [7:0] result,
  output logic            c_out
);
  logic       lo_big;
  logic       fix_lo;
  logic       fix_hi;
  logic [7:0] corr;

  // ---------------------------------------------------------------
  // correction select
  // ---------------------------------------------------------------
  always_comb begin
    lo_big = value[3:0] > `CBD_BCD_MAX;
    fix_lo = lo_big || h_in;
    fix_hi = (value[7:4] > `CBD_BCD_MAX) || c_in ||
             ((value[7:4] == `CBD_BCD_MAX) && lo_big);
    if (sub) begin
      // subtract: constant picked by carry and half carry
      unique case ({c_in, h_in})
        2'b00: corr = `CBD_ADJ_NONE;
        2'b01: corr = `CBD_ADJ_SUB_H;
        2'b10: corr = `CBD_ADJ_SUB_C;
        2'b11: corr = `CBD_ADJ_SUB_CH;
      endcase
      c_out = c_in;
    end else begin
      if (fix_hi && fix_lo) corr = `CBD_ADJ_BOTH;
      else if (fix_hi) corr = `CBD_ADJ_HI;
      else if (fix_lo) corr = `CBD_ADJ_LO;
      else corr = `CBD_ADJ_NONE;
      c_out = fix_hi;
    end
    result = value + corr;
  end
endmodule : cbd_bcd_adj
`default_nettype wire

// file: cbd_rf_model.sv
`timescale 1ns/10ps
`default_nettype none
module cbd_rf_model (
  // clock
  input  wire logic        clk,
  // register file port
  input  wire logic [11:0] rf_addr,
  input  wire logic        rf_rd,
  input  wire logic        rf_we,
  input  wire logic [7:0]  rf_wdata,
  output logic      [7:0]  rf_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] junk = 8'hA5;
  // read data stands while the strobe stands, scrambled otherwise
  assign rf_rdata = rf_rd ? mem[rf_addr] : junk;
  always @(posedge clk) begin
    junk <= ~junk;
    if (rf_we) mem[rf_addr] <= rf_wdata;
  end
endmodule : cbd_rf_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "cbd_map.svh"
module tb_top;
  logic        clk, rst_b, ins_valid, ins_prefix, ins_done, busy, pc_load;
  logic [7:0]  ins_opcode, ins_byte1, ins_byte2, ins_byte3, rp;
  logic [15:0] pc_target, pc_next;
  logic [11:0] rf_addr;
  logic        rf_rd, rf_we, ctl_wr, ctl_rd, took;
  logic [7:0]  rf_wdata, rf_rdata, ctl_wdata, ctl_rdata, flags, icr, rd;
  logic [1:0]  ctl_addr;
  int          fails, check_count, cyc;
  // ---------------------------------------------------------------
  // design and register file
  // ---------------------------------------------------------------
  cbd_exec dut_u (.clk(clk), .rst_b(rst_b), .ins_valid(ins_valid),
    .ins_prefix(ins_prefix), .ins_opcode(ins_opcode),
    .ins_byte1(ins_byte1), .ins_byte2(ins_byte2), .ins_byte3(ins_byte3),
    .ins_pc_next(pc_next), .register_pointer(rp), .ins_done(ins_done),
    .busy(busy), .pc_load(pc_load), .pc_target(pc_target),
    .rf_addr(rf_addr), .rf_rd(rf_rd), .rf_we(rf_we), .rf_wdata(rf_wdata),
    .rf_rdata(rf_rdata), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata),
    .ctl_wr(ctl_wr), .ctl_rd(ctl_rd), .ctl_rdata(ctl_rdata),
    .flags(flags), .interrupt_control_register(icr));
  cbd_rf_model rf_u (.clk(clk), .rf_addr(rf_addr), .rf_rd(rf_rd),
    .rf_we(rf_we), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata));
  // clock and cycle ceiling
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      wrap_up();
    end
  end
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic ctl_w(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    ctl_addr <= a;
    ctl_wdata <= d;
    ctl_wr <= 1'b1;
    @(posedge clk);
    ctl_wr <= 1'b0;
  endtask : ctl_w
  task automatic ctl_r(input logic [1:0] a);
    @(posedge clk);
    ctl_addr <= a;
    ctl_rd <= 1'b1;
    @(posedge clk);
    ctl_rd <= 1'b0;
    #1 rd = ctl_rdata;
  endtask : ctl_r
  task automatic run_op(input logic pre, input logic [7:0] op, b1, b2, b3);
    int n;
    @(posedge clk);
    ins_prefix <= pre;
    ins_opcode <= op;
    ins_byte1 <= b1;
    ins_byte2 <= b2;
    ins_byte3 <= b3;
    ins_valid <= 1'b1;
    @(posedge clk);
    ins_valid <= 1'b0;
    n = 0;
    took = 1'b0;
    #1;
    while (ins_done !== 1'b1 && n < 20) begin
      took = took | (pc_load === 1'b1);
      @(posedge clk);
      #1 n++;
    end
    took = took | (pc_load === 1'b1);
    if (n == 20) fails++;
    // let the model take the last register write
    @(posedge clk);
    #1;
  endtask : run_op
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_mask();
    chk("flags rst", flags, 16'h00);
    ctl_w(`CBD_OFS_ICTL, 8'h80);
    ctl_r(`CBD_OFS_ICTL);
    chk("icr read", rd, 16'h80);
    ctl_w(`CBD_OFS_FLAGS, 8'hF0);
    run_op(1'b0, `CBD_OP_MASK_ALL, 8'h00, 8'h00, 8'h00);
    chk("icr mask", icr, 16'h00);
    chk("flags mask", flags, 16'hF0);
  endtask : t_mask
  task automatic t_dec();
    rp <= 8'h00;
    rf_u.mem[12'h005] = 8'h01;
    ctl_w(`CBD_OFS_FLAGS, 8'h80);
    run_op(1'b0, `CBD_OP_DEC_R, 8'h05, 8'h00, 8'h00);
    chk("dec val", rf_u.mem[12'h005], 16'h00);
    chk("dec flags", flags, 16'hC0);
    rf_u.mem[12'h030] = 8'h0A;
    rf_u.mem[12'h031] = 8'hF2;
    run_op(1'b0, `CBD_OP_COUNT_DOWN_PAIR_R, 8'h31, 8'h00, 8'h00);
    chk("count_down_pair pair", {rf_u.mem[12'h030], rf_u.mem[12'h031]}, 16'h0AF1);
    chk("count_down_pair flags", flags, 16'h80);
    rf_u.mem[12'h0B3] = 8'hCB;
    rf_u.mem[12'h0CB] = 8'h01;
    run_op(1'b0, `CBD_OP_DEC_I, 8'hB3, 8'h00, 8'h00);
    chk("dec ind", rf_u.mem[12'h0CB], 16'h00);
    chk("dec ind flags", flags, 16'hC0);
    rf_u.mem[12'h000] = 8'h31;
    run_op(1'b0, `CBD_OP_COUNT_DOWN_PAIR_I, 8'hE0, 8'h00, 8'h00);
    chk("count_down_pair ind", {rf_u.mem[12'h030], rf_u.mem[12'h031]}, 16'h0AF0);
    chk("count_down_pair ind flags", flags, 16'h80);
  endtask : t_dec
  task automatic t_bcd(input logic [7:0] f, v, ev, ef);
    rf_u.mem[12'h05F] = v;
    ctl_w(`CBD_OFS_FLAGS, f);
    run_op(1'b0, `CBD_OP_BCD_R, 8'h5F, 8'h00, 8'h00);
    chk("bcd val", rf_u.mem[12'h05F], ev);
    chk("bcd flags", flags, ef);
  endtask : t_bcd
  task automatic t_loop();
    rp <= 8'h52;
    pc_next <= 16'h1234;
    rf_u.mem[12'h256] = 8'h03;
    ctl_w(`CBD_OFS_FLAGS, 8'h50);
    run_op(1'b0, 8'h6A, 8'hFE, 8'h00, 8'h00);
    chk("loop cnt", rf_u.mem[12'h256], 16'h02);
    chk("loop taken", took, 16'h1);
    chk("loop target", pc_target, 16'h1232);
    chk("loop flags", flags, 16'h50);
    pc_next <= 16'h2000;
    run_op(1'b0, 8'h6A, 8'h7F, 8'h00, 8'h00);
    chk("loop fwd", pc_target, 16'h207F);
    run_op(1'b0, 8'h6A, 8'h10, 8'h00, 8'h00);
    chk("loop end cnt", rf_u.mem[12'h256], 16'h00);
    chk("loop end", took, 16'h0);
    chk("loop hold", pc_target, 16'h207F);
    chk("loop end flags", flags, 16'h50);
    rf_u.mem[12'h25A] = 8'h80;
    run_op(1'b0, `CBD_OP_DEC_R, 8'hEA, 8'h00, 8'h00);
    chk("esc dec", rf_u.mem[12'h25A], 16'h7F);
    chk("esc flags", flags, 16'h10);
  endtask : t_loop
  task automatic t_cmp();
    rf_u.mem[12'h26C] = 8'h2A;
    ctl_w(`CBD_OFS_FLAGS, 8'h40);
    run_op(1'b1, `CBD_OP_CMPX_I, 8'h2A, 8'h02, 8'h6C);
    chk("cmpc z", flags, 16'h40);
    chk("cmpc keep", rf_u.mem[12'h26C], 16'h2A);
    ctl_w(`CBD_OFS_FLAGS, 8'h00);
    run_op(1'b1, `CBD_OP_CMPX_I, 8'h2A, 8'h02, 8'h6C);
    chk("cmpc z0", flags, 16'h00);
    ctl_w(`CBD_OFS_FLAGS, 8'hC0);
    run_op(1'b1, `CBD_OP_CMPX_I, 8'h29, 8'h02, 8'h6C);
    chk("cmpc cin", flags, 16'h40);
    rf_u.mem[12'hAB3] = 8'h16;
    rf_u.mem[12'h911] = 8'h20;
    run_op(1'b0, `CBD_OP_CMPX_R, 8'h91, 8'h1A, 8'hB3);
    chk("cmp flags", flags, 16'hA0);
  endtask : t_cmp
  task automatic t_stat();
    run_op(1'b1, `CBD_OP_DEC_R, 8'h00, 8'h00, 8'h00);
    ctl_r(`CBD_OFS_STAT);
    chk("stat bad", rd, 16'h04);
    ctl_w(`CBD_OFS_STAT, 8'h04);
    ctl_r(`CBD_OFS_STAT);
    chk("stat clr", rd, 16'h00);
  endtask : t_stat
  // ---------------------------------------------------------------
  // closing report and main sequence
  // ---------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  initial begin
    {clk, rst_b, ins_valid, ins_prefix, ctl_wr, ctl_rd} = '0;
    {ins_opcode, ins_byte1, ins_byte2, ins_byte3, rp, ctl_wdata} = '0;
    ctl_addr = '0;
    pc_next = 16'h1234;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    t_mask();
    t_dec();
    t_bcd(8'h00, 8'h3C, 8'h42, 8'h00);
    t_bcd(8'h1C, 8'h0E, 8'h08, 8'h1C);
    t_loop();
    t_cmp();
    t_stat();
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
